// *** design/rsu_access_unit.v ***
// serial slave access unit: status, strobes, registers, ram and buffer ports
// Functional notes
// - status byte out during first byte types
// - status layout osc underflow cipher tx lock rssi
// - underflow sticky until transmit flush strobe
// - signal valid after 128 us receive enabled
// - no-op strobe only returns status
// - oscillator off: only oscillator-on strobe works
// - other strobes dropped while oscillator unstable
// - strobe runs on last falling edge
// - banks: transmit, receive, security 112 bytes
// - ram address increments per data byte
// - ram write returns previous stored byte
// - ram read returns bytes after address
// - buffer ports at 0x3E and 0x3F
// - transmit port write-only, receive port both
// - status returned per transmit port byte
// - ram or port access ends by deselect
// - mixed accesses in one frame, ram last
// - flush strobes empty their buffers
// - ram retained, never cleared by reset
// - register frame: address byte, sixteen data bits
// - serial input sampled on rising clock
// - serial output released while deselected
`timescale 1ns/100ps
`include "rsu_access_regs.vh"
module rsu_access_unit #(
  parameter [15:0] RSSI_CYCLES = `RSU_RSSI_CYCLES
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        sclk,
  input  wire        chipSelectN,
  input  wire        serialIn,
  output reg         serialOut,
  output reg         serialOutEn,
  input  wire        oscStable,
  input  wire        cipherBusy,
  input  wire        txActive,
  input  wire        pllLock,
  input  wire        rxEnabled,
  input  wire        txUnderflowEvent,
  output reg         strobeValid,
  output reg  [5:0]  strobeCode,
  output reg         regWrite,
  output reg  [5:0]  regAddr,
  output reg  [15:0] regWrData,
  input  wire [15:0] regRdData,
  input  wire        rxInValid,
  input  wire [7:0]  rxInData,
  output reg         rxInReady,
  output reg  [7:0]  txByteCount,
  output reg  [7:0]  rxByteCount
);
  localparam [2:0] PH_CMD  = 3'd0;
  localparam [2:0] PH_REGH = 3'd1;
  localparam [2:0] PH_REGL = 3'd2;
  localparam [2:0] PH_RAMA = 3'd3;
  localparam [2:0] PH_RAM  = 3'd4;
  localparam [2:0] PH_TXP  = 3'd5;
  localparam [2:0] PH_RXP  = 3'd6;

  reg  [7:0]  ram [0:`RSU_RAM_BYTES-1];
  reg  [2:0]  sckSync;
  reg  [2:0]  csSync;
  reg  [2:0]  siSync;
  reg         sckF;
  reg         csF;
  reg         siF;
  reg  [2:0]  phase;
  reg  [2:0]  bitCnt;
  reg  [7:0]  inShift;
  reg  [7:0]  outShift;
  reg  [7:0]  loadByte;
  reg         loadPend;
  reg         strobePend;
  reg  [5:0]  pendCode;
  reg         accRead;
  reg         ramRdOnly;
  reg  [8:0]  ramAddr;
  reg  [7:0]  regHigh;
  reg         txUnderflow;
  reg  [15:0] rssiCnt;
  reg         rssiValid;
  reg  [6:0]  txWrPtr;
  reg  [6:0]  rxWrPtr;
  reg  [6:0]  rxRdPtr;
  reg  [7:0]  skid0;
  reg  [7:0]  skid1;
  reg  [1:0]  skidCnt;
  reg  [7:0]  statusByte;
  reg  [2:0]  next_phase;
  reg  [7:0]  next_out;
  reg         memWe;
  reg  [8:0]  memAddr;
  reg         txPush;
  reg         rxHostPush;
  reg         rxPop;
  reg         strobeHit;
  reg         ramStep;
  reg  [1:0]  next_skidCnt;

  // address inside the populated ram space
  function ramValid;
    input [8:0] a;
    begin
      ramValid = (a < `RSU_RAM_LIMIT);
    end
  endfunction

  // ram read with zero for unused locations
  function [7:0] ramRead;
    input [8:0] a;
    begin
      if (ramValid(a)) begin
        ramRead = ram[a];
      end else begin
        ramRead = 8'h00;
      end
    end
  endfunction

  // next filtered level: second and third stages agree
  wire sckNew = (sckSync[1] == sckSync[2]) ? sckSync[1] : sckF;
  wire csNew  = (csSync[1] == csSync[2]) ? csSync[1] : csF;
  wire siNew  = (siSync[1] == siSync[2]) ? siSync[1] : siF;
  wire sckRise  = ~csF & sckNew & ~sckF;
  wire sckFall  = ~csF & ~sckNew & sckF;
  wire csFall   = csF & ~csNew;
  wire csRise   = ~csF & csNew;
  wire byteDone = sckRise & (bitCnt == 3'd7);
  wire [7:0] rxByte = {inShift[6:0], siF};
  wire [7:0] rxHead = ram[{`RSU_BANK_RX, rxRdPtr}];
  wire strobeOk = oscStable | (pendCode == `RSU_STB_OSCON);
  wire strobeFire = sckFall & loadPend & strobePend & strobeOk;
  wire flushTx = strobeFire & (pendCode == `RSU_STB_FLUSHTX);
  wire flushRx = strobeFire & (pendCode == `RSU_STB_FLUSHRX);
  wire hostWr  = byteDone & memWe;
  wire drainGo = (skidCnt != 2'd0) & ~hostWr & ~flushRx & (rxByteCount < `RSU_BUF_BYTES);
  wire skidPush = rxInValid & rxInReady;

  // status byte assembly, reserved bits zero
  always @* begin
    statusByte = `RSU_STATUS_RESET;
    statusByte[`RSU_ST_OSC] = oscStable;
    statusByte[`RSU_ST_UNDERFLOW] = txUnderflow;
    statusByte[`RSU_ST_CIPHER] = cipherBusy;
    statusByte[`RSU_ST_TXACTIVE] = txActive;
    statusByte[`RSU_ST_LOCK] = pllLock;
    statusByte[`RSU_ST_RSSI] = rssiValid;
  end

  // decode of a completed byte per phase
  always @* begin
    next_phase = phase;
    next_out   = 8'h00;
    memWe      = 1'b0;
    memAddr    = ramAddr;
    txPush     = 1'b0;
    rxHostPush = 1'b0;
    rxPop      = 1'b0;
    strobeHit  = 1'b0;
    ramStep    = 1'b0;
    case (phase)
      PH_CMD: begin
        if (rxByte[`RSU_BIT_RAM]) begin
          next_phase = PH_RAMA;
        end else if (rxByte[5:0] == `RSU_TXPORT_ADDR) begin
          next_phase = PH_TXP;
          next_out = statusByte;
        end else if (rxByte[5:0] == `RSU_RXPORT_ADDR) begin
          next_phase = PH_RXP;
          if (rxByte[`RSU_BIT_READ]) begin
            next_out = rxHead;
            rxPop = (rxByteCount != `RSU_COUNT_RESET);
          end
        end else if (!rxByte[`RSU_BIT_READ] && rxByte[5:0] <= `RSU_STROBE_MAX) begin
          strobeHit = 1'b1;
          next_out = statusByte;
        end else begin
          next_phase = PH_REGH;
          next_out = regRdData[15:8];
        end
      end
      PH_REGH: begin
        next_phase = PH_REGL;
        next_out = regRdData[7:0];
      end
      PH_REGL: begin
        next_phase = PH_CMD;
        next_out = statusByte;
      end
      PH_RAMA: begin
        next_phase = PH_RAM;
        next_out = ramRead({rxByte[7:6], ramAddr[6:0]});
      end
      PH_RAM: begin
        memWe = ~ramRdOnly & ramValid(ramAddr);
        ramStep = 1'b1;
        next_out = ramRead(ramAddr + 9'd1);
      end
      PH_TXP: begin
        memWe = (txByteCount < `RSU_BUF_BYTES);
        memAddr = {`RSU_BANK_TX, txWrPtr};
        txPush = memWe;
        next_out = statusByte;
      end
      PH_RXP: begin
        if (accRead) begin
          next_out = rxHead;
          rxPop = (rxByteCount != `RSU_COUNT_RESET);
        end else begin
          memWe = (rxByteCount < `RSU_BUF_BYTES);
          memAddr = {`RSU_BANK_RX, rxWrPtr};
          rxHostPush = memWe;
        end
      end
      default: begin
        next_phase = PH_CMD;
      end
    endcase
  end

  // ram storage, no reset so contents survive
  always @(posedge clk_sys) begin
    if (hostWr) begin
      ram[memAddr] <= rxByte;
    end else if (drainGo) begin
      ram[{`RSU_BANK_RX, rxWrPtr}] <= skid0;
    end
  end

  // three-stage pin synchronisers and agreement filter
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sckSync <= 3'b000;
      csSync  <= 3'b111;
      siSync  <= 3'b000;
      sckF    <= 1'b0;
      csF     <= 1'b1;
      siF     <= 1'b0;
    end else begin
      sckSync <= {sckSync[1:0], sclk};
      csSync  <= {csSync[1:0], chipSelectN};
      siSync  <= {siSync[1:0], serialIn};
      sckF    <= sckNew;
      csF     <= csNew;
      siF     <= siNew;
    end
  end

  // serial engine: shift, byte decode, output loading, strobes
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase       <= PH_CMD;
      bitCnt      <= 3'd0;
      inShift     <= 8'h00;
      outShift    <= 8'h00;
      loadByte    <= 8'h00;
      loadPend    <= 1'b0;
      strobePend  <= 1'b0;
      pendCode    <= 6'h00;
      accRead     <= 1'b0;
      ramRdOnly   <= 1'b0;
      ramAddr     <= 9'h000;
      regHigh     <= 8'h00;
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
      strobeValid <= 1'b0;
      strobeCode  <= 6'h00;
      regWrite    <= 1'b0;
      regAddr     <= 6'h00;
      regWrData   <= 16'h0000;
    end else begin
      strobeValid <= 1'b0;
      regWrite    <= 1'b0;
      if (csRise) begin
        phase       <= PH_CMD;
        bitCnt      <= 3'd0;
        loadPend    <= 1'b0;
        strobePend  <= 1'b0;
        serialOutEn <= 1'b0;
      end else if (csFall) begin
        phase       <= PH_CMD;
        bitCnt      <= 3'd0;
        serialOutEn <= 1'b1;
        serialOut   <= statusByte[7];
        outShift    <= {statusByte[6:0], 1'b0};
      end else begin
        if (sckRise) begin
          inShift <= rxByte;
          bitCnt  <= bitCnt + 3'd1;
        end
        if (byteDone) begin
          phase    <= next_phase;
          loadByte <= next_out;
          loadPend <= 1'b1;
          if (phase == PH_CMD) begin
            accRead     <= rxByte[`RSU_BIT_READ];
            regAddr     <= rxByte[5:0];
            ramAddr[6:0] <= rxByte[6:0];
            strobePend  <= strobeHit;
            pendCode    <= rxByte[5:0];
          end
          if (phase == PH_RAMA) begin
            ramAddr[8:7] <= rxByte[7:6];
            ramRdOnly    <= rxByte[`RSU_BIT_RDONLY];
          end
          if (ramStep) begin
            ramAddr <= ramAddr + 9'd1;
          end
          if (phase == PH_REGH) begin
            regHigh <= rxByte;
          end
          if (phase == PH_REGL && !accRead) begin
            regWrite  <= 1'b1;
            regWrData <= {regHigh, rxByte};
          end
        end
        if (sckFall) begin
          if (loadPend) begin
            serialOut  <= loadByte[7];
            outShift   <= {loadByte[6:0], 1'b0};
            loadPend   <= 1'b0;
            strobePend <= 1'b0;
            if (strobeFire && pendCode != `RSU_STB_NOP) begin
              strobeValid <= 1'b1;
              strobeCode  <= pendCode;
            end
          end else begin
            serialOut <= outShift[7];
            outShift  <= {outShift[6:0], 1'b0};
          end
        end
      end
    end
  end

  // buffer counters, pointers and sticky underflow
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txByteCount <= `RSU_COUNT_RESET;
      rxByteCount <= `RSU_COUNT_RESET;
      txWrPtr     <= 7'd0;
      rxWrPtr     <= 7'd0;
      rxRdPtr     <= 7'd0;
      txUnderflow <= 1'b0;
    end else begin
      txUnderflow <= txUnderflowEvent | (txUnderflow & ~flushTx);
      if (flushTx) begin
        txByteCount <= `RSU_COUNT_RESET;
        txWrPtr     <= 7'd0;
      end else if (byteDone && txPush) begin
        txByteCount <= txByteCount + 8'd1;
        txWrPtr     <= txWrPtr + 7'd1;
      end
      if (flushRx) begin
        rxByteCount <= `RSU_COUNT_RESET;
        rxWrPtr     <= 7'd0;
        rxRdPtr     <= 7'd0;
      end else begin
        if ((byteDone && rxHostPush) || drainGo) begin
          rxWrPtr <= rxWrPtr + 7'd1;
        end
        if (byteDone && rxPop) begin
          rxRdPtr <= rxRdPtr + 7'd1;
        end
        rxByteCount <= rxByteCount + {7'd0, (byteDone & rxHostPush) | drainGo} - {7'd0, byteDone & rxPop};
      end
    end
  end

  // signal strength valid after enough receive cycles
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rssiCnt   <= 16'h0000;
      rssiValid <= 1'b0;
    end else if (!rxEnabled) begin
      rssiCnt   <= 16'h0000;
      rssiValid <= 1'b0;
    end else begin
      if (rssiCnt < RSSI_CYCLES) begin
        rssiCnt <= rssiCnt + 16'h0001;
      end
      rssiValid <= (rssiCnt >= RSSI_CYCLES - 16'h0001);
    end
  end

  // two-entry buffer between radio bytes and receive bank
  always @* begin
    next_skidCnt = skidCnt + {1'b0, skidPush} - {1'b0, drainGo};
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skid0     <= 8'h00;
      skid1     <= 8'h00;
      skidCnt   <= 2'd0;
      rxInReady <= 1'b0;
    end else begin
      if (drainGo) begin
        skid0 <= skid1;
      end
      if (skidPush) begin
        if (skidCnt == {1'b0, drainGo}) begin
          skid0 <= rxInData;
        end else begin
          skid1 <= rxInData;
        end
      end
      skidCnt   <= next_skidCnt;
      rxInReady <= (next_skidCnt != 2'd2);
    end
  end
endmodule

// *** design/rsu_access_regs.vh ***
// constants for the radio serial access unit
`ifndef RSU_ACCESS_REGS_VH
`define RSU_ACCESS_REGS_VH
// port addresses and strobe range
`define RSU_TXPORT_ADDR    6'h3E
`define RSU_RXPORT_ADDR    6'h3F
`define RSU_STROBE_MAX     6'h0E
// strobe codes
`define RSU_STB_NOP        6'h00
`define RSU_STB_OSCON      6'h01
`define RSU_STB_FLUSHRX    6'h02
`define RSU_STB_FLUSHTX    6'h03
// status byte bit positions
`define RSU_ST_OSC         6
`define RSU_ST_UNDERFLOW   5
`define RSU_ST_CIPHER      4
`define RSU_ST_TXACTIVE    3
`define RSU_ST_LOCK        2
`define RSU_ST_RSSI        1
// access byte fields
`define RSU_BIT_RAM        7
`define RSU_BIT_READ       6
`define RSU_BIT_RDONLY     5
// memory layout
`define RSU_RAM_BYTES      368
`define RSU_RAM_LIMIT      9'h170
`define RSU_BUF_BYTES      8'h80
`define RSU_BANK_TX        2'b00
`define RSU_BANK_RX        2'b01
// reset values
`define RSU_STATUS_RESET   8'h00
`define RSU_COUNT_RESET    8'h00
// timing
`define RSU_CLK_PERIOD_NS  10
`define RSU_SIGNAL_STRENGTH_VALID_FLAG_US  128
`define RSU_RSSI_CYCLES    16'd12800 // 128 us of 10 ns clock cycles
`endif

// *** verif/rsu_access_unit_monitor.sv ***
// port assertions for the serial access unit
`timescale 1ns/100ps
module rsu_access_monitor (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       chipSelectN,
  input wire logic       oscStable,
  input wire logic       serialOutEn,
  input wire logic       strobeValid,
  input wire logic [5:0] strobeCode,
  input wire logic [7:0] txByteCount,
  input wire logic [7:0] rxByteCount
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // settled deselect and select spans
  sequence s_idle;
    chipSelectN [*5];
  endsequence
  sequence s_sel;
    !chipSelectN [*7];
  endsequence
  // output enable follows the select
  property p_oe_off;
    s_idle |-> !serialOutEn;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
  property p_oe_on;
    s_sel |-> serialOutEn;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven in frame");
  // executed strobes
  property p_stb_code;
    strobeValid |-> strobeCode != 6'h00 && strobeCode <= 6'h0E;
  endproperty
  a_stb_code: assert property (p_stb_code) else $error("bad strobe code");
  property p_osc_gate;
    strobeValid && strobeCode != 6'h01 |-> $past(oscStable);
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("strobe with osc off");
  property p_stb_pulse;
    strobeValid |=> !strobeValid;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe pulse long");
  // flush and counter behaviour
  property p_tx_flush;
    strobeValid && strobeCode == 6'h03 |-> ##[0:1] txByteCount == 8'h00;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx not flushed");
  property p_rx_flush;
    strobeValid && strobeCode == 6'h02 |-> ##[0:1] rxByteCount == 8'h00;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx not flushed");
  property p_tx_step;
    !$stable(txByteCount) |-> txByteCount == $past(txByteCount) + 8'h01 || txByteCount == 8'h00;
  endproperty
  a_tx_step: assert property (p_tx_step) else $error("tx count jump");
  property p_tx_cap;
    txByteCount <= 8'h80;
  endproperty
  a_tx_cap: assert property (p_tx_cap) else $error("tx count over size");
endmodule

// *** verif/rsu_host_model.sv ***
// serial master model of the host
`timescale 1ns/100ps
module rsu_host_model (
  output logic sclk,
  output logic chipSelectN,
  output logic serialIn,
  input  wire  soPin
);
  initial begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b1;
  end
  // open frame, clock idles low
  task start();
    chipSelectN = 1'b0;
    #80;
  endtask
  // one byte, msb first, out sampled on rise
  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serialIn = tx[i];
      #80 sclk = 1'b1;
      rx[i] = soPin;
      #80 sclk = 1'b0;
    end
  endtask
  // deselect ends the frame and any ram or port access
  task stop();
    #80 chipSelectN = 1'b1;
    serialIn = ~serialIn;
  endtask
endmodule

// *** verif/rsu_access_unit_test.sv ***
// self-checking bench of the serial access unit
`timescale 1ns/100ps
`include "rsu_access_regs.vh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nErrors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module rsu_access_unit_test;
  logic clk_sys = 0, rst = 1, oscStable = 0, cipherBusy = 0, txActive = 0;
  logic pllLock = 0, rxEnabled = 0, txUnderflowEvent = 0, rxInValid = 0;
  logic [7:0] rxInData = 8'h00, st, r;
  logic [15:0] regRdData = 16'h0000, wData;
  logic [5:0] lastCode, wAddr;
  wire sclk, chipSelectN, serialIn, serialOut, serialOutEn, strobeValid, regWrite, rxInReady;
  wire [5:0] strobeCode, regAddr;
  wire [15:0] regWrData;
  wire [7:0] txByteCount, rxByteCount;
  wire soPin = serialOutEn ? serialOut : 1'b1; // pull-up on the line
  int nErrors = 0, cmpCount = 0, nStb = 0, cycles = 0;
  rsu_access_unit #(.RSSI_CYCLES(16'd20)) u_dut (.clk_sys, .rst, .sclk, .chipSelectN,
    .serialIn, .serialOut, .serialOutEn, .oscStable, .cipherBusy, .txActive, .pllLock,
    .rxEnabled, .txUnderflowEvent, .strobeValid, .strobeCode, .regWrite, .regAddr,
    .regWrData, .regRdData, .rxInValid, .rxInData, .rxInReady, .txByteCount, .rxByteCount);
  rsu_host_model hm (.sclk, .chipSelectN, .serialIn, .soPin);
  always #5 clk_sys = ~clk_sys;
  // event capture and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (strobeValid !== 1'b0) begin
      nStb++;
      lastCode = strobeCode;
    end
    if (regWrite !== 1'b0) begin
      wAddr = regAddr;
      wData = regWrData;
    end
    if (cycles == 20000) begin
      nErrors++;
      finishTest();
    end
  end
  task tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task strobe(input logic [5:0] c);
    hm.start();
    hm.xbyte({2'b00, c}, st);
    hm.stop();
    tick(10);
  endtask
  task t_osc();
    int n;
    n = nStb;
    strobe(6'h04);
    `CHK(nStb, n)
    `CHK(st[6], 1'b0)
    strobe(`RSU_STB_OSCON);
    `CHK(lastCode, `RSU_STB_OSCON)
    oscStable = 1'b1;
    tick(4);
    strobe(6'h04);
    `CHK(nStb, n + 2)
  endtask
  task t_status();
    int n;
    cipherBusy = 1'b1;
    pllLock = 1'b1;
    txActive = 1'b1;
    txUnderflowEvent = 1'b1;
    tick(1);
    txUnderflowEvent = 1'b0;
    n = nStb;
    strobe(`RSU_STB_NOP);
    `CHK(st & 8'h7E, 8'h7C)
    `CHK(nStb, n)
    rxEnabled = 1'b1;
    tick(25);
    strobe(`RSU_STB_NOP);
    `CHK(st & 8'h7E, 8'h7E)
    strobe(`RSU_STB_FLUSHTX);
    strobe(`RSU_STB_NOP);
    `CHK(st[5], 1'b0)
  endtask
  task t_tx();
    hm.start();
    hm.xbyte({2'b00, `RSU_STB_FLUSHTX}, st);
    hm.xbyte({2'b00, `RSU_TXPORT_ADDR}, st);
    for (int i = 0; i < 3; i++) begin
      hm.xbyte(8'hA0 + 8'(i), r);
      `CHK(r & 8'h7E, 8'h5E)
    end
    hm.stop();
    tick(8);
    `CHK(txByteCount, 8'h03)
    hm.start();
    hm.xbyte(8'h80, st);
    hm.xbyte(8'h20, r);
    for (int i = 0; i < 3; i++) begin
      hm.xbyte(8'h00, r);
      `CHK(r, 8'hA0 + 8'(i))
    end
    hm.stop();
    tick(8);
  endtask
  task t_ram();
    hm.start();
    hm.xbyte(8'hEE, st);
    hm.xbyte(8'h80, r);
    for (int i = 0; i < 3; i++) hm.xbyte(8'h51 + 8'(i), r);
    hm.stop();
    tick(8);
    hm.start();
    hm.xbyte(8'hEE, st);
    hm.xbyte(8'h80, r);
    hm.xbyte(8'h5A, r);
    `CHK(r, 8'h51)
    hm.xbyte(8'h00, r);
    `CHK(r, 8'h52)
    hm.xbyte(8'h00, r);
    `CHK(r, 8'h00)
    hm.stop();
    tick(8);
  endtask
  task t_reg();
    regRdData = 16'h1234;
    hm.start();
    hm.xbyte({2'b00, `RSU_STB_NOP}, st);
    hm.xbyte(8'h10, st);
    hm.xbyte(8'hBE, r);
    hm.xbyte(8'hEF, r);
    hm.xbyte(8'h50, st);
    hm.xbyte(8'h00, r);
    `CHK(r, 8'h12)
    hm.xbyte(8'h00, r);
    `CHK(r, 8'h34)
    hm.stop();
    tick(8);
    `CHK(wAddr, 6'h10)
    `CHK(wData, 16'hBEEF)
  endtask
  task t_rx();
    for (int i = 0; i < 3; i++) begin
      rxInValid = 1'b1;
      rxInData = 8'hC0 + 8'(i);
      while (rxInReady !== 1'b1) tick(1);
      tick(1);
    end
    rxInValid = 1'b0;
    tick(8);
    `CHK(rxByteCount, 8'h03)
    hm.start();
    hm.xbyte({2'b01, `RSU_RXPORT_ADDR}, st);
    for (int i = 0; i < 3; i++) begin
      hm.xbyte(8'h00, r);
      `CHK(r, 8'hC0 + 8'(i))
    end
    hm.stop();
    tick(8);
    `CHK(rxByteCount, 8'h00)
    hm.start();
    hm.xbyte({2'b00, `RSU_RXPORT_ADDR}, st);
    hm.xbyte(8'h3C, r);
    hm.stop();
    tick(8);
    `CHK(rxByteCount, 8'h01)
    strobe(`RSU_STB_FLUSHRX);
    `CHK(rxByteCount, 8'h00)
  endtask
  task finishTest();
    $display("errors %0d compares %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    tick(8);
    t_osc();
    t_status();
    t_tx();
    t_ram();
    t_reg();
    t_rx();
    finishTest();
  end
endmodule
bind rsu_access_unit rsu_access_monitor u_mon (.clk_sys, .rst, .chipSelectN, .oscStable,
  .serialOutEn, .strobeValid, .strobeCode, .txByteCount, .rxByteCount);
